// [core/tarb_defs.svh]
`ifndef TARB_DEFS_SVH
`define TARB_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TARB_OFS_FRESH 7'h01
`define TARB_OFS_BUFCTL 7'h02
`define TARB_OFS_REFCTL 7'h03
`define TARB_OFS_SRST 7'h04
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define TARB_BUF_EN_BIT 15
`define TARB_BUF_MODE_BIT 14
`define TARB_BUF_FULL_BIT 10
`define TARB_BUF_EMPTY_BIT 9
`define TARB_REF_SRC_BIT 4
`define TARB_REF_PWR_BIT 1
`define TARB_REF_LVL_BIT 0
`define TARB_SRST_CODE 16'hBB00
`define TARB_SRST_RESET 16'hFFFF
`define TARB_REF_RESET 6'h02
`define TARB_BUF_DEPTH 7'h40
// ----------------------------------------
// timing
// ----------------------------------------
`define TARB_CLK_MHZ 10
`define TARB_SETTLE1_US 100
`define TARB_SETTLE2_US 500
`define TARB_SETTLE3_US 1000
`define TARB_SETTLE1_CYC (`TARB_SETTLE1_US * `TARB_CLK_MHZ)
`define TARB_SETTLE2_CYC (`TARB_SETTLE2_US * `TARB_CLK_MHZ)
`define TARB_SETTLE3_CYC (`TARB_SETTLE3_US * `TARB_CLK_MHZ)
`endif

// [core/tarb_pkg.sv]
package tarb_pkg;
  typedef struct packed {
    logic buf_en;
    logic buf_mode;
    logic [2:0] trig_lvl;
    logic ref_rsvd;
    logic ref_src;
    logic [1:0] settle;
    logic ref_pwr;
    logic ref_lvl;
  } tarb_ctrl_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_GO = 3'b100
  } tarb_state_type;
endpackage

// [core/tarb_regs.sv]
`include "tarb_defs.svh"
// Operation
// - X and Y fresh flags at D10, D9
// - pressure fresh flags at D8, D7
// - supply, extra inputs flags D6, D4, D3
// - thermal flags D2, D1; D5, D0 zero
// - flag clears after channel fully read
// - buffer enable zero holds pointers reset
// - mode bit: continuous or single shot
// - trigger level is eight times code plus eight
// - full flag when 64 unread results
// - empty flag when none unread; resets 1
// - source bit: external or internal reference
// - settling wait 0, 100, 500, 1000 us
// - wait only internal and power-down mode
// - power bit: always on or cycled
// - external source keeps internal reference off
// - level bit: 1.25 V or 2.50 V
// - code BB00 restores control defaults
module tarb_regs
  import tarb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [6:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [9:0] CH_NEW,
  input wire logic [9:0] CH_READ_DONE,
  input wire logic BUF_PUSH,
  input wire logic BUF_POP,
  input wire logic CONV_REQ,
  output logic [15:0] RDATA,
  output logic BUF_EN,
  output logic BUF_SINGLE,
  output logic [5:0] BUF_RD_PTR,
  output logic [5:0] BUF_WR_PTR,
  output logic [5:0] BUF_TRIG_PTR,
  output logic BUF_TRIG,
  output logic REF_INTERNAL,
  output logic REF_ON,
  output logic REF_HIGH,
  output logic CONV_GO
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [9:0] fresh_ff, nxt_fresh;
  tarb_ctrl_type ctrl_ff, nxt_ctrl;
  logic [15:0] srst_ff, nxt_srst;
  logic [5:0] rptr_ff, nxt_rptr, wptr_ff, nxt_wptr, tptr_ff, nxt_tptr;
  logic [6:0] cnt_ff, nxt_cnt;
  logic trig_ff, nxt_trig;
  tarb_state_type st_ff, nxt_st;
  logic [13:0] wait_ff, nxt_wait;
  logic go_ff, nxt_go;
  logic ron_ff, nxt_ron;
  logic [15:0] rdata_ff, nxt_rdata;
  logic srst_hit;
  logic do_push, do_pop;

  // code 0 gives 8 entries, code 7 the full depth of 64
  function automatic logic [6:0] trig_depth(input logic [2:0] code);
    trig_depth = {code, 3'h0} + 7'h08;
  endfunction

  function automatic logic [13:0] settle_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: settle_cycles = 14'h0000;
      2'h1: settle_cycles = 14'(`TARB_SETTLE1_CYC);
      2'h2: settle_cycles = 14'(`TARB_SETTLE2_CYC);
      2'h3: settle_cycles = 14'(`TARB_SETTLE3_CYC);
    endcase
  endfunction

  assign srst_hit = WR_EN && ADDR == `TARB_OFS_SRST && WDATA == `TARB_SRST_CODE;
  // a push when full or a pop when empty is dropped, so the count never wraps
  assign do_push = ctrl_ff.buf_en && BUF_PUSH && cnt_ff != `TARB_BUF_DEPTH;
  assign do_pop = ctrl_ff.buf_en && BUF_POP && cnt_ff != 7'h00;

  // ----------------------------------------
  // fresh flags and control
  // ----------------------------------------
  always_comb
  begin
    // channel order: x y pa pb supply ex1 ex2 th1 th2 placed below
    // a read finishing in the cycle of new data must not drop the new flag
    nxt_fresh = (fresh_ff & ~CH_READ_DONE) | CH_NEW;
    nxt_ctrl = ctrl_ff;
    nxt_srst = srst_ff;
    if (WR_EN && ADDR == `TARB_OFS_BUFCTL)
    begin
      nxt_ctrl.buf_en = WDATA[`TARB_BUF_EN_BIT];
      nxt_ctrl.buf_mode = WDATA[`TARB_BUF_MODE_BIT];
      nxt_ctrl.trig_lvl = WDATA[13:11];
    end
    if (WR_EN && ADDR == `TARB_OFS_REFCTL)
    begin
      nxt_ctrl.ref_rsvd = WDATA[5];
      nxt_ctrl.ref_src = WDATA[`TARB_REF_SRC_BIT];
      nxt_ctrl.settle = WDATA[3:2];
      nxt_ctrl.ref_pwr = WDATA[`TARB_REF_PWR_BIT];
      nxt_ctrl.ref_lvl = WDATA[`TARB_REF_LVL_BIT];
    end
    if (WR_EN && ADDR == `TARB_OFS_SRST)
      nxt_srst = WDATA;
    if (srst_hit)
    begin
      nxt_ctrl = '0;
      nxt_ctrl.ref_pwr = 1'b1;
      nxt_srst = `TARB_SRST_RESET;
    end
  end

  // ----------------------------------------
  // buffer pointers
  // ----------------------------------------
  always_comb
  begin
    nxt_rptr = rptr_ff + 6'(do_pop);
    nxt_wptr = wptr_ff + 6'(do_push);
    nxt_cnt = cnt_ff + 7'(do_push) - 7'(do_pop);
    nxt_tptr = tptr_ff;
    nxt_trig = trig_ff;
    if (do_push && nxt_cnt == trig_depth(ctrl_ff.trig_lvl))
    begin
      nxt_trig = 1'b1;
      nxt_tptr = nxt_wptr;
    end
    else if (nxt_cnt < trig_depth(ctrl_ff.trig_lvl))
      nxt_trig = 1'b0;
    if (!nxt_ctrl.buf_en)
    begin
      nxt_rptr = 6'h00;
      nxt_wptr = 6'h00;
      nxt_tptr = 6'h00;
      nxt_cnt = 7'h00;
      nxt_trig = 1'b0;
    end
  end

  // ----------------------------------------
  // reference settling sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_wait = wait_ff;
    nxt_go = 1'b0;
    unique case (st_ff)
      ST_IDLE:
        if (CONV_REQ)
        begin
          // only a cycled internal reference needs to settle
          if (ctrl_ff.ref_src && ctrl_ff.ref_pwr && ctrl_ff.settle != 2'h0)
          begin
            nxt_wait = settle_cycles(ctrl_ff.settle) - 14'h0001;
            nxt_st = ST_SETTLE;
          end
          else
            nxt_st = ST_GO;
        end
      ST_SETTLE:
        if (wait_ff == 14'h0000)
          nxt_st = ST_GO;
        else
          nxt_wait = wait_ff - 14'h0001;
      ST_GO:
      begin
        nxt_go = 1'b1;
        nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
    // a cycled reference wakes only while a conversion is pending
    nxt_ron = nxt_ctrl.ref_src && (!nxt_ctrl.ref_pwr || nxt_st != ST_IDLE);
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb
  begin
    // unmapped offsets read zero; the last read value holds until the next read
    nxt_rdata = rdata_ff;
    if (RD_EN)
    begin
      unique case (ADDR)
        `TARB_OFS_FRESH: nxt_rdata = {5'h00, fresh_ff[9:5], 1'b0, fresh_ff[4:1], 1'b0};
        `TARB_OFS_BUFCTL: nxt_rdata = {ctrl_ff.buf_en, ctrl_ff.buf_mode, ctrl_ff.trig_lvl,
          cnt_ff == `TARB_BUF_DEPTH, cnt_ff == 7'h00, 9'h000};
        `TARB_OFS_REFCTL: nxt_rdata = {10'h000, ctrl_ff.ref_rsvd, ctrl_ff.ref_src,
          ctrl_ff.settle, ctrl_ff.ref_pwr, ctrl_ff.ref_lvl};
        `TARB_OFS_SRST: nxt_rdata = srst_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      fresh_ff <= 10'h000;
      ctrl_ff <= '0;
      ctrl_ff.ref_pwr <= 1'b1;
      srst_ff <= `TARB_SRST_RESET;
      rptr_ff <= 6'h00;
      wptr_ff <= 6'h00;
      tptr_ff <= 6'h00;
      cnt_ff <= 7'h00;
      trig_ff <= 1'b0;
      st_ff <= ST_IDLE;
      wait_ff <= 14'h0000;
      go_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      ron_ff <= 1'b0;
    end
    else
    begin
      fresh_ff <= nxt_fresh;
      ctrl_ff <= nxt_ctrl;
      srst_ff <= nxt_srst;
      rptr_ff <= nxt_rptr;
      wptr_ff <= nxt_wptr;
      tptr_ff <= nxt_tptr;
      cnt_ff <= nxt_cnt;
      trig_ff <= nxt_trig;
      st_ff <= nxt_st;
      wait_ff <= nxt_wait;
      go_ff <= nxt_go;
      rdata_ff <= nxt_rdata;
      ron_ff <= nxt_ron;
    end
  end

  // ----------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------
  assign RDATA = rdata_ff;
  assign BUF_EN = ctrl_ff.buf_en;
  assign BUF_SINGLE = ctrl_ff.buf_mode;
  assign BUF_RD_PTR = rptr_ff;
  assign BUF_WR_PTR = wptr_ff;
  assign BUF_TRIG_PTR = tptr_ff;
  assign BUF_TRIG = trig_ff;
  assign REF_INTERNAL = ctrl_ff.ref_src;
  assign REF_ON = ron_ff;
  assign REF_HIGH = ctrl_ff.ref_lvl;
  assign CONV_GO = go_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_FRESH_SET: assert property (@(posedge CLK) disable iff (RST)
    CH_NEW[9] |=> fresh_ff[9]) else $error("fresh flag not set");
  AST_FRESH_CLR: assert property (@(posedge CLK) disable iff (RST)
    CH_READ_DONE[3] && !CH_NEW[3] |=> !fresh_ff[3]) else $error("fresh flag not cleared");
  AST_FRESH_WIN: assert property (@(posedge CLK) disable iff (RST)
    CH_READ_DONE[9] && CH_NEW[9] |=> fresh_ff[9]) else $error("new data lost");
  AST_BUF_OFF: assert property (@(posedge CLK) disable iff (RST)
    !BUF_EN |-> BUF_RD_PTR == 6'h00 && BUF_WR_PTR == 6'h00) else $error("pointer moved");
  AST_FULL_RD: assert property (@(posedge CLK) disable iff (RST)
    RD_EN && ADDR == 7'h02 && cnt_ff == 7'h40 |=> RDATA[10]) else $error("full flag wrong");
  AST_EMPTY_RD: assert property (@(posedge CLK) disable iff (RST)
    RD_EN && ADDR == 7'h02 |=> RDATA[9] == ($past(cnt_ff) == 7'h00)) else $error("empty wrong");
  AST_EXT_OFF: assert property (@(posedge CLK) disable iff (RST)
    !REF_INTERNAL |-> !REF_ON) else $error("reference on in external mode");
  AST_NO_WAIT: assert property (@(posedge CLK) disable iff (RST)
    st_ff == ST_IDLE && CONV_REQ && !ctrl_ff.ref_pwr |=> ##1 CONV_GO) else $error("go late");
  AST_SRST: assert property (@(posedge CLK) disable iff (RST)
    srst_hit |=> !BUF_EN && !REF_INTERNAL && ctrl_ff.ref_pwr) else $error("soft reset failed");
  AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (RST)
    RD_EN && ADDR == `TARB_OFS_FRESH |=> RDATA[5] == 1'b0 && RDATA[0] == 1'b0)
    else $error("reserved status bit set");
  AST_MODE_WR: assert property (@(posedge CLK) disable iff (RST)
    WR_EN && ADDR == `TARB_OFS_BUFCTL |=> BUF_SINGLE == $past(WDATA[`TARB_BUF_MODE_BIT]))
    else $error("mode bit not taken");
  AST_TRIG_HIT: assert property (@(posedge CLK) disable iff (RST)
    do_push && !WR_EN && cnt_ff + 7'h01 == trig_depth(ctrl_ff.trig_lvl) |=> BUF_TRIG)
    else $error("trigger not raised");
  AST_FULL_HOLD: assert property (@(posedge CLK) disable iff (RST)
    cnt_ff == `TARB_BUF_DEPTH && BUF_PUSH && !BUF_POP && !WR_EN |=> $stable(BUF_WR_PTR))
    else $error("push accepted when full");
  AST_SRC_WR: assert property (@(posedge CLK) disable iff (RST)
    WR_EN && ADDR == `TARB_OFS_REFCTL |=> REF_INTERNAL == $past(WDATA[`TARB_REF_SRC_BIT]))
    else $error("source bit not taken");
  AST_SETTLE_END: assert property (@(posedge CLK) disable iff (RST)
    st_ff == ST_SETTLE && wait_ff == 14'h0000 |=> ##1 CONV_GO)
    else $error("go missing after settle");
  AST_SETTLE_SKIP: assert property (@(posedge CLK) disable iff (RST)
    st_ff == ST_IDLE && CONV_REQ && !(ctrl_ff.ref_src && ctrl_ff.ref_pwr) |=> st_ff == ST_GO)
    else $error("settle wait inserted");
  AST_INT_ON: assert property (@(posedge CLK) disable iff (RST)
    REF_INTERNAL && !ctrl_ff.ref_pwr |-> REF_ON)
    else $error("reference off in always-on mode");
  AST_LVL_WR: assert property (@(posedge CLK) disable iff (RST)
    WR_EN && ADDR == `TARB_OFS_REFCTL |=> REF_HIGH == $past(WDATA[`TARB_REF_LVL_BIT]))
    else $error("level bit not taken");
endmodule

// [tb/tarb_host.sv]
`include "tarb_defs.svh"
module tarb_host (
  input wire logic CLK,
  input wire logic [15:0] RDATA,
  output logic WR_EN,
  output logic RD_EN,
  output logic [6:0] ADDR,
  output logic [15:0] WDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 7'h00;
    WDATA = 16'h0000;
  end
  task wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == `TARB_OFS_REFCTL)
      v[5] = 1'b0;
    if (a == `TARB_OFS_SRST)
      v = `TARB_SRST_CODE;
    @(negedge CLK);
    WR_EN = 1'b1;
    ADDR = a;
    WDATA = v;
    @(negedge CLK);
    WR_EN = 1'b0;
    WDATA = ~v;
  endtask
  task rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge CLK);
    RD_EN = 1'b1;
    ADDR = a;
    @(negedge CLK);
    d = RDATA;
    RD_EN = 1'b0;
  endtask
endmodule

// [tb/touch_adc_status_buffer_ref_regs_tb_top.sv]
module touch_adc_status_buffer_ref_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_en, push, pop, conv_req, buf_en, buf_single, buf_trig;
  logic ref_int, ref_on, ref_high, conv_go;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  logic [9:0] ch_new, ch_done;
  logic [5:0] rd_ptr, wr_ptr, trig_ptr;
  int n_errors = 0;
  int cmp_count = 0;
  int settle[4] = '{0, 1000, 5000, 10000};
  always #50 clk = ~clk;
  tarb_host host (.CLK(clk), .RDATA(rdata), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
    .WDATA(wdata));
  tarb_regs dut (.CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
    .WDATA(wdata), .CH_NEW(ch_new), .CH_READ_DONE(ch_done), .BUF_PUSH(push), .BUF_POP(pop),
    .CONV_REQ(conv_req), .RDATA(rdata), .BUF_EN(buf_en), .BUF_SINGLE(buf_single),
    .BUF_RD_PTR(rd_ptr), .BUF_WR_PTR(wr_ptr), .BUF_TRIG_PTR(trig_ptr), .BUF_TRIG(buf_trig),
    .REF_INTERNAL(ref_int), .REF_ON(ref_on), .REF_HIGH(ref_high), .CONV_GO(conv_go));
  task give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask
  task ev(input logic [9:0] nw, input logic [9:0] dn);
    @(negedge clk);
    ch_new = nw;
    ch_done = dn;
    @(negedge clk);
    ch_new = 10'h000;
    ch_done = 10'h000;
  endtask
  // ----------------------------------------
  // buffer traffic, one result per cycle
  // ----------------------------------------
  task bufop(input logic p, input int n);
    @(negedge clk);
    push = p;
    pop = ~p;
    repeat (n) @(negedge clk);
    push = 1'b0;
    pop = 1'b0;
  endtask
  task conv(input int exp_n);
    int n;
    @(negedge clk);
    conv_req = 1'b1;
    @(negedge clk);
    conv_req = 1'b0;
    n = 1;
    while (conv_go !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    chk("go delay", exp_n[15:0], n[15:0]);
  endtask
  initial
  begin
    {ch_new, ch_done, push, pop, conv_req} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rchk(7'h01, 16'h0000);
    rchk(7'h02, 16'h0200);
    rchk(7'h03, 16'h0002);
    rchk(7'h04, 16'hFFFF);
    rchk(7'h05, 16'h0000);
    ev(10'h3FE, 10'h000);
    rchk(7'h01, 16'h07DE);
    ev(10'h200, 10'h300);
    rchk(7'h01, 16'h05DE);
    ev(10'h000, 10'h0FE);
    rchk(7'h01, 16'h0400);
    // flags are not read again while the buffer runs
    bufop(1'b1, 1);
    rchk(7'h02, 16'h0200);
    host.wr(7'h02, 16'hC000);
    rchk(7'h02, 16'hC200);
    chk("single", 16'h0001, {15'h0000, buf_single});
    bufop(1'b1, 7);
    chk("trig7", 16'h0000, {15'h0000, buf_trig});
    bufop(1'b1, 1);
    chk("trig8", 16'h0001, {15'h0000, buf_trig});
    chk("wr ptr8", 16'h0008, {10'h000, wr_ptr});
    host.wr(7'h02, 16'hF800);
    bufop(1'b1, 55);
    chk("trig63", 16'h0000, {15'h0000, buf_trig});
    rchk(7'h02, 16'hF800);
    bufop(1'b1, 2);
    chk("trig64", 16'h0001, {15'h0000, buf_trig});
    rchk(7'h02, 16'hFC00);
    bufop(1'b0, 1);
    rchk(7'h02, 16'hF800);
    chk("ptrs run", 16'h0040, {4'h0, rd_ptr, wr_ptr});
    host.wr(7'h02, 16'h0000);
    chk("ptrs", 16'h0000, {rd_ptr, wr_ptr, trig_ptr[3:0]});
    chk("cont", 16'h0000, {15'h0000, buf_single});
    rchk(7'h02, 16'h0200);
    for (int k = 0; k < 4; k++)
    begin
      host.wr(7'h03, {11'h000, 1'b1, k[1:0], 2'b11});
      chk("int", 16'h0001, {15'h0000, ref_int});
      chk("high", 16'h0001, {15'h0000, ref_high});
      chk("cycled off", 16'h0000, {15'h0000, ref_on});
      conv(2 + settle[k]);
    end
    host.wr(7'h03, 16'h0006);
    chk("ext on", 16'h0000, {15'h0000, ref_on});
    conv(2);
    host.wr(7'h03, 16'h0000);
    chk("ext on0", 16'h0000, {15'h0000, ref_on});
    host.wr(7'h03, 16'h0030);
    chk("int on", 16'h0001, {15'h0000, ref_on});
    chk("low", 16'h0000, {15'h0000, ref_high});
    rchk(7'h03, 16'h0010);
    conv(2);
    host.wr(7'h02, 16'hC000);
    host.wr(7'h04, 16'hBB00);
    rchk(7'h02, 16'h0200);
    rchk(7'h03, 16'h0002);
    rchk(7'h04, 16'hFFFF);
    give_verdict();
  end
  initial
  begin
    #(40000 * 100);
    n_errors++;
    give_verdict();
  end
endmodule
